// [rtl/svce_ecnt.sv]
`timescale 1ns/1ps
// accumulator for data units read
module svce_ecnt #(
    parameter int W = 64
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // block counted
    input  wire logic         inc,
    // total
    output logic [W-1:0]      total_q
);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            total_q <= W'(svce_pkg::DATA_UNITS_RST);
        end else if (inc) begin
            total_q <= total_q + W'(1);
        end
    end
endmodule : svce_ecnt

// [rtl/svce_engine.sv]
`timescale 1ns/1ps
module svce_engine #(
    parameter int CNT_W = 64
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // namespace format
    input  wire logic                  ns_pi_enabled,
    input  wire logic                  ns_ref_tag_valid,
    // command in
    input  wire logic                  cmd_valid,
    input  svce_pkg::svce_cmd_t        cmd,
    output logic                       cmd_ready_q,
    // cache flush
    output logic                       flush_req_q,
    output logic [63:0]                flush_lba_q,
    output logic [15:0]                flush_count_q,
    input  wire logic                  flush_done,
    // media read
    output logic                       rd_valid_q,
    output svce_pkg::svce_rd_t         rd_q,
    input  wire logic                  rd_ready,
    input  wire logic                  rsp_valid,
    input  svce_pkg::svce_rsp_t        rsp,
    output logic [3:0]                 retry_budget_q,
    // completion out
    output logic                       cpl_entry_valid_q,
    output svce_pkg::svce_cpl_entry_t  cpl_entry_q,
    input  wire logic                  cpl_entry_ready,
    // health counter
    output logic [CNT_W-1:0]           data_units_read_q
);
    typedef enum logic [2:0] {S_IDLE, S_FLUSH, S_ISSUE, S_WAIT, S_DONE} svce_state_t;

    svce_state_t  state_q;
    logic [63:0]  lba_q;
    logic [16:0]  left_q;
    logic         limited_retry_q;
    logic         fma_q;
    logic [2:0]   chk_q;
    logic [31:0]  ref_q;
    logic [15:0]  tag_q;
    logic [15:0]  mask_q;
    logic         blk_done;

    // dword 13 is never read; data only leaves as status
    wire logic [3:0]  protection_info_field =
                          cmd.dw12[svce_pkg::FLD_PROT_FIELD_LO +: 4];
    wire logic        protection_insert_strip_action =
                          cmd.dw12[svce_pkg::FLD_PROT_ACTION_BIT];
    wire logic [15:0] block_count_minus_one =
                          cmd.dw12[svce_pkg::FLD_COUNT_LO +: 16];
    wire logic        bad_pi  = (protection_info_field[2:0] != 3'h0 && !ns_pi_enabled) ||
                                (ns_pi_enabled && protection_info_field[0] &&
                                 !ns_ref_tag_valid);
    wire logic        take    = cmd_valid && cmd_ready_q;
    wire logic        any_err = rsp.read_err || rsp.guard_err || rsp.app_err || rsp.ref_err;

    assign blk_done = (state_q == S_WAIT) && rsp_valid;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q     <= S_IDLE;
            cmd_ready_q <= 1'b1;
            cpl_entry_valid_q <= 1'b0;
            cpl_entry_q       <= '0;
            flush_req_q <= 1'b0;
            rd_valid_q  <= 1'b0;
            left_q      <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        cmd_ready_q <= 1'b0;
                        cpl_entry_q.cid <= cmd.cid;
                        if (protection_insert_strip_action) begin
                            cpl_entry_q.sct <= svce_pkg::SCT_GENERIC;
                            cpl_entry_q.sc  <= svce_pkg::SC_INV_FIELD;
                            state_q         <= S_DONE;
                        end else if (bad_pi) begin
                            cpl_entry_q.sct <= svce_pkg::SCT_CMD_SPEC;
                            cpl_entry_q.sc  <= svce_pkg::SC_INV_PROT;
                            state_q         <= S_DONE;
                        end else begin
                            cpl_entry_q.sct <= svce_pkg::SCT_GENERIC;
                            cpl_entry_q.sc  <= svce_pkg::SC_SUCCESS;
                            left_q    <= {1'b0, block_count_minus_one} + 17'd1;
                            // flush first so the media copy is what gets checked
                            flush_req_q <= cmd.dw12[svce_pkg::FLD_FMA_BIT];
                            state_q     <= cmd.dw12[svce_pkg::FLD_FMA_BIT] ? S_FLUSH : S_ISSUE;
                        end
                    end
                end
                S_FLUSH: begin
                    if (flush_done) begin
                        flush_req_q <= 1'b0;
                        state_q     <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    rd_valid_q <= 1'b1;
                    if (rd_valid_q && rd_ready) begin
                        rd_valid_q <= 1'b0;
                        state_q    <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (rsp_valid) begin
                        left_q <= left_q - 17'd1;
                        if (any_err) begin
                            // media status passes through as a read would give it
                            cpl_entry_q.sct <= svce_pkg::SCT_MEDIA;
                            cpl_entry_q.sc  <= rsp.sc;
                            state_q   <= S_DONE;
                        end else begin
                            state_q <= (left_q == 17'd1) ? S_DONE : S_ISSUE;
                        end
                    end
                end
                S_DONE: begin
                    cpl_entry_valid_q <= 1'b1;
                    if (cpl_entry_valid_q && cpl_entry_ready) begin
                        cpl_entry_valid_q <= 1'b0;
                        cmd_ready_q <= 1'b1;
                        state_q     <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // per-command options
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            limited_retry_q <= 1'b0;
            fma_q  <= 1'b0;
            chk_q  <= '0;
            ref_q  <= '0;
            tag_q  <= '0;
            mask_q <= '0;
        end else if (take) begin
            limited_retry_q <= cmd.dw12[svce_pkg::FLD_RETRY_BIT];
            fma_q  <= cmd.dw12[svce_pkg::FLD_FMA_BIT];
            // tags only matter with protection formatting
            chk_q  <= ns_pi_enabled ? cmd.dw12[svce_pkg::FLD_PROT_CHECK_LO +: 3] : 3'h0;
            ref_q  <= ns_pi_enabled ? cmd.dw14 : 32'h0000_0000;
            tag_q  <= ns_pi_enabled ? cmd.dw15[15:0] : 16'h0000;
            mask_q <= ns_pi_enabled ? cmd.dw15[31:16] : 16'h0000;
        end
    end

    // address walk and flush range
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lba_q         <= '0;
            flush_lba_q   <= '0;
            flush_count_q <= '0;
        end else if (take) begin
            lba_q         <= {cmd.dw11, cmd.dw10};
            flush_lba_q   <= {cmd.dw11, cmd.dw10};
            flush_count_q <= cmd.dw12[15:0];
        end else if (blk_done) begin
            lba_q <= lba_q + 64'd1;
        end
    end

    // read request; data stays inside the engine
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_q           <= '0;
            retry_budget_q <= svce_pkg::RETRY_FULL;
        end else begin
            rd_q.lba                     <= lba_q;
            rd_q.limited_retry           <= limited_retry_q;
            rd_q.from_media              <= fma_q;
            rd_q.protection_check_select <= chk_q;
            // reference tag advances one per block
            rd_q.ref_tag                 <= ref_q + 32'(lba_q - flush_lba_q);
            rd_q.app_tag                 <= tag_q;
            rd_q.app_tag_mask            <= mask_q;
            retry_budget_q <= limited_retry_q ? svce_pkg::RETRY_LIMITED
                                              : svce_pkg::RETRY_FULL;
        end
    end

    // every checked block counts, failed ones included
    svce_ecnt #(
        .W(CNT_W)
    ) u_cnt (
        .clock   (clock),
        .nrst    (nrst),
        .inc     (blk_done),
        .total_q (data_units_read_q)
    );
endmodule : svce_engine

// [shared/svce_pkg.sv]
package svce_pkg;

    // command dword field positions
    localparam int FLD_RETRY_BIT       = 31;
    localparam int FLD_FMA_BIT         = 30;
    localparam int FLD_PROT_FIELD_LO   = 26;
    localparam int FLD_PROT_ACTION_BIT = 29;
    localparam int FLD_PROT_CHECK_LO   = 26;
    localparam int FLD_COUNT_LO        = 0;

    // status types and codes
    localparam logic [2:0] SCT_GENERIC   = 3'h0;
    localparam logic [2:0] SCT_CMD_SPEC  = 3'h1;
    localparam logic [2:0] SCT_MEDIA     = 3'h2;
    localparam logic [7:0] SC_SUCCESS    = 8'h00;
    localparam logic [7:0] SC_INV_FIELD  = 8'h02;
    localparam logic [7:0] SC_INV_PROT   = 8'h81;

    // reset values and retry budgets
    localparam logic [63:0] DATA_UNITS_RST = 64'h0000_0000_0000_0000;
    localparam logic [3:0]  RETRY_LIMITED  = 4'h1;
    localparam logic [3:0]  RETRY_FULL     = 4'h8;

    typedef struct packed {
        logic [15:0] cid;
        logic [31:0] dw10;
        logic [31:0] dw11;
        logic [31:0] dw12;
        logic [31:0] dw14;
        logic [31:0] dw15;
    } svce_cmd_t;

    typedef struct packed {
        logic [15:0] cid;
        logic [2:0]  sct;
        logic [7:0]  sc;
    } svce_cpl_entry_t;

    // block read request toward the media
    typedef struct packed {
        logic [63:0] lba;
        logic        limited_retry;
        logic        from_media;
        logic [2:0]  protection_check_select;
        logic [31:0] ref_tag;
        logic [15:0] app_tag;
        logic [15:0] app_tag_mask;
    } svce_rd_t;

    // media answer for one block
    typedef struct packed {
        logic       read_err;
        logic       guard_err;
        logic       app_err;
        logic       ref_err;
        logic [7:0] sc;
    } svce_rsp_t;

endpackage : svce_pkg

// [verification/svce_engine_sva.sv]
`timescale 1ns/1ps
module svce_engine_sva #(
    parameter int CNT_W = 64
) (
    // clock and reset
    input wire logic             clock,
    input wire logic             nrst,
    // command side
    input wire logic             ns_pi_enabled,
    input wire logic             cmd_valid,
    input svce_pkg::svce_cmd_t   cmd,
    input wire logic             cmd_ready_q,
    // media side
    input wire logic             flush_req_q,
    input wire logic             rd_valid_q,
    input svce_pkg::svce_rd_t    rd_q,
    input wire logic             rd_ready,
    input wire logic             rsp_valid,
    input wire logic [3:0]       retry_budget_q,
    // completion and counter
    input wire logic             cpl_entry_valid_q,
    input svce_pkg::svce_cpl_entry_t cpl_entry_q,
    input wire logic             cpl_entry_ready,
    input wire logic [CNT_W-1:0] data_units_read_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence take_s; cmd_valid && cmd_ready_q; endsequence
    sequence action_done_s;
        cpl_entry_valid_q && cpl_entry_q.sct == svce_pkg::SCT_GENERIC
            && cpl_entry_q.sc == svce_pkg::SC_INV_FIELD;
    endsequence
    sequence prot_done_s;
        cpl_entry_valid_q && cpl_entry_q.sct == svce_pkg::SCT_CMD_SPEC
            && cpl_entry_q.sc == svce_pkg::SC_INV_PROT;
    endsequence
    a_action_abort: assert property (take_s and cmd.dw12[29] |-> ##2 action_done_s)
        else $error("insert/strip action not aborted");
    a_prot_bad: assert property (take_s and !cmd.dw12[29] && !ns_pi_enabled
        && cmd.dw12[28:26] != 3'h0 |-> ##2 prot_done_s) else $error("bad protection not flagged");
    a_busy_after: assert property (take_s |=> !cmd_ready_q)
        else $error("second command accepted");
    a_cpl_hold: assert property (cpl_entry_valid_q && !cpl_entry_ready
        |=> cpl_entry_valid_q && $stable(cpl_entry_q)) else $error("completion dropped");
    a_rd_hold: assert property (rd_valid_q && !rd_ready |=> rd_valid_q && $stable(rd_q.lba))
        else $error("read request dropped");
    a_units_count: assert property (rsp_valid |=> data_units_read_q == $past(data_units_read_q) + 1)
        else $error("data units not counted");
    a_retry_pick: assert property (rd_valid_q |-> retry_budget_q == (rd_q.limited_retry
        ? svce_pkg::RETRY_LIMITED : svce_pkg::RETRY_FULL)) else $error("retry budget wrong");
    a_flush_first: assert property (take_s and cmd.dw12[30] && cmd.dw12[29:26] == 4'h0
        |-> ##[1:2] flush_req_q) else $error("no flush before check");
    a_no_flush: assert property (take_s and !cmd.dw12[30] |=> (!flush_req_q) [*3])
        else $error("flush without force access");
    a_flush_excl: assert property (flush_req_q |-> !rd_valid_q)
        else $error("read during flush");
endmodule : svce_engine_sva
bind svce_engine svce_engine_sva #(.CNT_W(CNT_W)) u_sva (.clock(clock), .nrst(nrst),
    .ns_pi_enabled(ns_pi_enabled), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q),
    .flush_req_q(flush_req_q), .rd_valid_q(rd_valid_q), .rd_q(rd_q), .rd_ready(rd_ready),
    .rsp_valid(rsp_valid), .retry_budget_q(retry_budget_q),
    .cpl_entry_valid_q(cpl_entry_valid_q), .cpl_entry_q(cpl_entry_q),
    .cpl_entry_ready(cpl_entry_ready), .data_units_read_q(data_units_read_q));

// [verification/svce_media_model.sv]
`timescale 1ns/1ps
// media and cache stand-in; slow adds wait cycles before accepting a read
module svce_media_model #(
    parameter logic [7:0] ERR_SC = 8'h81
) (
    input wire logic            clock,
    input wire logic            nrst,
    input wire logic            flush_req,
    input wire logic            rd_valid,
    input svce_pkg::svce_rd_t   rd,
    input wire logic [63:0]     err_lba,
    input wire logic            slow,
    output logic                flush_done,
    output logic                rd_ready,
    output logic                rsp_valid,
    output svce_pkg::svce_rsp_t rsp
);
    logic [1:0] wait_q;
    logic       hit;
    assign hit = rd.lba == err_lba;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flush_done <= 1'b0;
            rd_ready   <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp        <= '0;
            wait_q     <= 2'h0;
        end else begin
            flush_done <= flush_req && !flush_done;
            rd_ready   <= rd_valid && !rd_ready && wait_q == 2'h0;
            wait_q     <= rd_valid ? (wait_q == 2'h0 ? 2'h0 : wait_q - 2'h1) : {slow, 1'b0};
            rsp_valid  <= rd_valid && rd_ready;
            // stale answer bits flip so nothing can lean on them
            rsp <= (rd_valid && rd_ready) ? {hit, 3'h0, hit ? ERR_SC : 8'h00} : ~rsp;
        end
    end
endmodule : svce_media_model

// [verification/test_storage_verify_command_engine.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_storage_verify_command_engine;
    logic clock, nrst, ns_pi_enabled, ns_ref_tag_valid, cmd_valid, cpl_entry_ready, slow;
    logic flush_req_q, flush_done, rd_valid_q, rd_ready, rsp_valid, cmd_ready_q;
    logic cpl_entry_valid_q;
    logic [63:0] flush_lba_q, err_lba, data_units_read_q;
    logic [15:0] flush_count_q;
    logic [3:0]  retry_budget_q, last_budget;
    svce_pkg::svce_cmd_t cmd;
    svce_pkg::svce_rd_t  rd_q, last_rd;
    svce_pkg::svce_rsp_t rsp;
    svce_pkg::svce_cpl_entry_t cpl_entry_q;
    logic [63:0] lbas[$];
    int mismatches, cmp_count, cycles;
    svce_engine DUT (.clock(clock), .nrst(nrst), .ns_pi_enabled(ns_pi_enabled),
        .ns_ref_tag_valid(ns_ref_tag_valid), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_q(cmd_ready_q), .flush_req_q(flush_req_q), .flush_lba_q(flush_lba_q),
        .flush_count_q(flush_count_q), .flush_done(flush_done), .rd_valid_q(rd_valid_q),
        .rd_q(rd_q), .rd_ready(rd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .retry_budget_q(retry_budget_q), .cpl_entry_valid_q(cpl_entry_valid_q),
        .cpl_entry_q(cpl_entry_q), .cpl_entry_ready(cpl_entry_ready),
        .data_units_read_q(data_units_read_q));
    svce_media_model media (.clock(clock), .nrst(nrst), .flush_req(flush_req_q),
        .rd_valid(rd_valid_q), .rd(rd_q), .err_lba(err_lba), .slow(slow),
        .flush_done(flush_done), .rd_ready(rd_ready), .rsp_valid(rsp_valid), .rsp(rsp));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rd_valid_q && rd_ready) begin
            lbas.push_back(rd_q.lba);
            last_rd = rd_q;
            last_budget = retry_budget_q;
        end
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // one command end to end; completion held a cycle to exercise the stall
    task automatic run(input svce_pkg::svce_cmd_t c, input logic [2:0] sct,
                       input logic [7:0] sc, input int nb);
        logic [63:0] u0;
        int n;
        u0 = data_units_read_q;
        lbas.delete();
        n = 0;
        `CHK(cmd_ready_q, 1'b1)
        cmd_valid = 1'b1;
        cmd = c;
        @(negedge clock);
        cmd_valid = 1'b0;
        while (cpl_entry_valid_q !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        `CHK(cpl_entry_q, {c.cid, sct, sc})
        `CHK(data_units_read_q, u0 + 64'(nb))
        `CHK(lbas.size(), nb)
        if (nb > 0) `CHK(lbas[0], {c.dw11, c.dw10})
        cpl_entry_ready = 1'b1;
        @(negedge clock);
        cpl_entry_ready = 1'b0;
    endtask : run
    task automatic scen_pi_span();
        ns_pi_enabled = 1'b1;
        run('{16'h0001, 32'hFFFF_FFFF, 32'h0000_0001, 32'h9C00_0002, 32'h0000_0010,
              32'hF0F0_1234}, svce_pkg::SCT_GENERIC, svce_pkg::SC_SUCCESS, 3);
        `CHK(lbas[2], 64'h0000_0002_0000_0001)
        `CHK(last_rd.protection_check_select, 3'h7)
        `CHK(last_rd.ref_tag, 32'h0000_0012)
        `CHK({last_rd.app_tag_mask, last_rd.app_tag}, 32'hF0F0_1234)
        `CHK({last_rd.limited_retry, last_rd.from_media, last_budget}, 6'h21)
    endtask : scen_pi_span
    task automatic scen_fma_error();
        ns_pi_enabled = 1'b0;
        slow = 1'b1;
        err_lba = 64'h0000_0000_0000_0065;
        run('{16'h0002, 32'h0000_0064, 32'h0, 32'h4000_0003, 32'h0, 32'h0},
            svce_pkg::SCT_MEDIA, 8'h81, 2);
        `CHK({last_rd.limited_retry, last_rd.from_media, last_budget}, 6'h18)
        `CHK(flush_lba_q, 64'h0000_0000_0000_0064)
        `CHK(flush_count_q, 16'h0003)
        slow = 1'b0;
    endtask : scen_fma_error
    task automatic scen_bad_fields();
        run('{16'h0003, 32'h0, 32'h0, 32'h3000_0000, 32'h0, 32'h0},
            svce_pkg::SCT_GENERIC, svce_pkg::SC_INV_FIELD, 0);
        run('{16'h0004, 32'h0, 32'h0, 32'h1000_0000, 32'h0, 32'h0},
            svce_pkg::SCT_CMD_SPEC, svce_pkg::SC_INV_PROT, 0);
        ns_pi_enabled = 1'b1;
        ns_ref_tag_valid = 1'b0;
        run('{16'h0005, 32'h0, 32'h0, 32'h0400_0000, 32'h0, 32'h0},
            svce_pkg::SCT_CMD_SPEC, svce_pkg::SC_INV_PROT, 0);
    endtask : scen_bad_fields
    initial begin
        {nrst, ns_pi_enabled, cmd_valid, cpl_entry_ready, slow} = 5'h00;
        ns_ref_tag_valid = 1'b1;
        cmd = '0;
        err_lba = '1;
        {mismatches, cmp_count, cycles} = '0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        scen_pi_span();
        scen_fma_error();
        scen_bad_fields();
        tally_and_finish();
    end
endmodule : test_storage_verify_command_engine
